// file: bench/hbfs_host_model.sv
// Host model: drives the register port, reads and clears flags
module hbfs_host_model
  import hbfs_pkg::*;
(
  // Clock
  input  wire logic               core_clk,
  // Register port
  output hbfs_pkg::hbfs_bus_req_t bus_req,
  input  wire logic [15:0]        bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port from time zero
  initial bus_req = '0;

  // One strobe cycle; read data only valid in the following cycle
  task automatic access(input logic [3:0] a, input logic [15:0] d,
                        input logic w, output logic [15:0] q);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    bus_req <= '0;
    #1 q = bus_rdata;
  endtask

  // Write-one-to-clear; a flag still fed by its cause sets again
  task automatic clear_flags(input logic [3:0] a, input logic [15:0] m);
    logic [15:0] q;
    access(a, m, 1'b1, q);
  endtask
endmodule

// file: bench/tb_hbfs_top.sv
// Testbench: fault supervisor with random bridge setup and fault cases
module tb_hbfs_top;
  import hbfs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic          core_clk  = 1'b0;
  logic          rst_n     = 1'b0;
  hbfs_bus_req_t bus_req;
  logic [15:0]   bus_rdata;
  hbfs_mon_t     mon       = '0;
  logic [11:0]   hs_oc     = 12'h000;
  logic [11:0]   ls_oc     = 12'h000;
  logic          supply_ok = 1'b1;
  logic          act_pin   = 1'b1;
  logic [11:0]   hs_on;
  logic [11:0]   ls_on;
  logic [11:0]   oe;
  logic [11:0]   ehs;
  logic [11:0]   els;
  logic [11:0]   hon;
  logic [11:0]   lon;
  logic [11:0]   m;
  logic [15:0]   q;
  int            err_total = 0;
  int            n_checks  = 0;

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  hbfs_top hbfs_top_i (.core_clk(core_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .mon_raw(mon),
    .hs_oc_raw(hs_oc), .ls_oc_raw(ls_oc), .logic_supply_ok(supply_ok),
    .activation_pin(act_pin), .high_side_switch_on(hs_on),
    .low_side_switch_on(ls_on), .stage_oe(oe));

  hbfs_host_model host_i (.core_clk(core_clk), .bus_req(bus_req),
    .bus_rdata(bus_rdata));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [15:0] exp);
    logic [15:0] d;
    host_i.access(a, 16'h0000, 1'b0, d);
    chk(nm, d, exp);
  endtask

  // Both drive vectors and the enable that follows them
  task automatic outs(input logic [11:0] h, l);
    chk("hs_on", {4'h0, hs_on}, {4'h0, h});
    chk("ls_on", {4'h0, ls_on}, {4'h0, l});
    chk("stage_oe", {4'h0, oe}, {4'h0, h | l});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cross conduction is never allowed, whatever the stimulus
  always @(negedge core_clk) begin
    if (rst_n === 1'b1)
      chk("overlap", {4'h0, hs_on & ls_on}, 16'h0000);
  end

  // Hang guard, far beyond the few thousand cycles expected
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(18));
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    rd_chk("global", ADDR_GLOBAL, 16'h0000);
    rd_chk("unmapped", 4'hF, 16'h0000);
    // Random bridges; bridge 0 asks for both switches at once
    ehs = (12'($urandom) & ~12'h004) | 12'h003;
    els = (12'($urandom) & ~ehs) | 12'h005;
    hon = ehs & ~els;
    lon = els & ~ehs;
    host_i.access(ADDR_HS_ACT, {4'h0, ehs}, 1'b1, q);
    host_i.access(ADDR_LS_ACT, {4'h0, els}, 1'b1, q);
    tick(40);
    outs(hon, lon);
    // Swap bridge 1 to its low switch and back; each way waits dead time
    host_i.access(ADDR_HS_ACT, {4'h0, ehs & ~12'h002}, 1'b1, q);
    host_i.access(ADDR_LS_ACT, {4'h0, els | 12'h002}, 1'b1, q);
    tick(5);
    outs(hon & ~12'h002, lon);
    tick(35);
    outs(hon & ~12'h002, lon | 12'h002);
    host_i.access(ADDR_HS_ACT, {4'h0, ehs}, 1'b1, q);
    host_i.access(ADDR_LS_ACT, {4'h0, els}, 1'b1, q);
    tick(5);
    outs(hon & ~12'h002, lon);
    tick(35);
    outs(hon, lon);
    // Overcurrent on a high switch, then on a low switch
    for (int s = 0; s < 2; s++) begin
      m = s ? 12'h004 : 12'h002;
      tick(1);
      if (s == 0) hs_oc <= m;
      else ls_oc <= m;
      tick(SD_FILTER_CYC + 15);
      outs(s ? hon : hon & ~m, s ? lon & ~m : lon);
      hs_oc <= 12'h000;
      ls_oc <= 12'h000;
      tick(40);
      outs(s ? hon : hon & ~m, s ? lon & ~m : lon);
      rd_chk("oc_flag", ADDR_HS_OC + 4'(s), {4'h0, m});
      rd_chk("global", ADDR_GLOBAL, 16'h0040);
      rd_chk("hs_act", ADDR_HS_ACT, {4'h0, ehs});
      rd_chk("ls_act", ADDR_LS_ACT, {4'h0, els});
      host_i.clear_flags(ADDR_HS_OC + 4'(s), {4'h0, m});
      tick(40);
      outs(hon, lon);
      rd_chk("global", ADDR_GLOBAL, 16'h0000);
    end
    // Thermal warning leaves the stages running
    tick(1);
    mon.temp_warn <= 1'b1;
    tick(8);
    outs(hon, lon);
    host_i.clear_flags(ADDR_GLOBAL, 16'h0002);
    rd_chk("warn_hot", ADDR_GLOBAL, 16'h0002);
    tick(1);
    mon.temp_warn <= 1'b0;
    tick(6);
    rd_chk("warn_held", ADDR_GLOBAL, 16'h0002);
    host_i.clear_flags(ADDR_GLOBAL, 16'h0002);
    rd_chk("warn_clr", ADDR_GLOBAL, 16'h0000);
    // Thermal shutdown, clear attempted while still hot
    tick(1);
    mon.temp_sd <= 1'b1;
    tick(8);
    outs(12'h000, 12'h000);
    host_i.clear_flags(ADDR_GLOBAL, 16'h0004);
    rd_chk("tsd_hot", ADDR_GLOBAL, 16'h0004);
    tick(1);
    mon.temp_sd <= 1'b0;
    tick(40);
    outs(12'h000, 12'h000);
    host_i.clear_flags(ADDR_GLOBAL, 16'h0004);
    tick(40);
    outs(hon, lon);
    // Load supply under- and overvoltage recover on their own
    for (int i = 0; i < 2; i++) begin
      tick(1);
      if (i == 0) mon.supply_undervoltage_flag <= 1'b1;
      else mon.supply_overvoltage_flag <= 1'b1;
      tick(8);
      outs(12'h000, 12'h000);
      mon.supply_undervoltage_flag <= 1'b0;
      mon.supply_overvoltage_flag <= 1'b0;
      tick(40);
      outs(hon, lon);
      rd_chk("vs_flag", ADDR_GLOBAL, i ? 16'h0010 : 16'h0020);
      host_i.clear_flags(ADDR_GLOBAL, 16'h0030);
      rd_chk("vs_clr", ADDR_GLOBAL, 16'h0000);
    end
    // Logic supply loss wipes state and releases the stages
    host_i.access(ADDR_GLOBAL, 16'h0008, 1'b1, q);
    rd_chk("powup_set", ADDR_GLOBAL, 16'h0008);
    tick(1);
    supply_ok <= 1'b0;
    tick(8);
    outs(12'h000, 12'h000);
    supply_ok <= 1'b1;
    tick(6);
    rd_chk("powup", ADDR_GLOBAL, 16'h0000);
    rd_chk("hs_act_rst", ADDR_HS_ACT, 16'h0000);
    outs(12'h000, 12'h000);
    // Power-up bit cannot be set outside normal mode
    tick(1);
    act_pin <= 1'b0;
    tick(4);
    host_i.access(ADDR_GLOBAL, 16'h0008, 1'b1, q);
    rd_chk("powup_idle", ADDR_GLOBAL, 16'h0000);
    end_sim();
  end
endmodule

// file: rtl/hbfs_leg.sv
// One half-bridge leg: overcurrent filter, latch and dead time
module hbfs_leg
  import hbfs_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic hs_act,
  input  wire logic ls_act,
  input  wire logic stage_ok,
  input  wire logic hs_oc_raw,
  input  wire logic ls_oc_raw,
  input  wire logic hs_clr,
  input  wire logic ls_clr,
  // Results
  output logic      hs_oc_flag,
  output logic      ls_oc_flag,
  output logic      hs_on,
  output logic      ls_on
);
  typedef struct packed {
    logic [FCNT_W-1:0] hs_cnt;
    logic [FCNT_W-1:0] ls_cnt;
    logic              hs_flag;
    logic              ls_flag;
    logic [DCNT_W-1:0] dead;
    logic              hs_on;
    logic              ls_on;
  } hbfs_leg_st_t;
  hbfs_leg_st_t st_reg, st_next;
  logic hs_want, ls_want;
  localparam logic [FCNT_W-1:0] FLT = FCNT_W'(SD_FILTER_CYC - 1);

  // Next state
  always_comb begin
    st_next = st_reg;
    // Filter current above threshold while switch is on
    if (hs_oc_raw && st_reg.hs_on) st_next.hs_cnt = st_reg.hs_cnt + 1'b1;
    else st_next.hs_cnt = '0;
    if (ls_oc_raw && st_reg.ls_on) st_next.ls_cnt = st_reg.ls_cnt + 1'b1;
    else st_next.ls_cnt = '0;
    // Set beats clear; a persisting fault re-latches
    if (hs_clr) st_next.hs_flag = 1'b0;
    if (ls_clr) st_next.ls_flag = 1'b0;
    if (st_reg.hs_cnt >= FLT && hs_oc_raw && st_reg.hs_on) begin // RL1 RL2
      st_next.hs_flag = 1'b1; // RL26
      st_next.hs_cnt = '0;
    end
    if (st_reg.ls_cnt >= FLT && ls_oc_raw && st_reg.ls_on) begin // RL1 RL2
      st_next.ls_flag = 1'b1; // RL26
      st_next.ls_cnt = '0;
    end
    // Latched flag keeps its switch off whatever the control bit
    hs_want = hs_act && stage_ok && !st_next.hs_flag; // RL4
    ls_want = ls_act && stage_ok && !st_next.ls_flag; // RL4
    // Turn-off is immediate; turn-on waits out the dead time
    if (!hs_want) st_next.hs_on = 1'b0;
    if (!ls_want) st_next.ls_on = 1'b0;
    if (st_reg.dead != '0) st_next.dead = st_reg.dead - 1'b1;
    if (hs_want && ls_want) begin
      // Both asked for: neither drives, cross conduction is never allowed
      st_next.hs_on = 1'b0; // RL7
      st_next.ls_on = 1'b0;
    end else if (st_reg.dead == '0 && !st_reg.ls_on && !st_reg.hs_on) begin
      st_next.hs_on = hs_want;
      st_next.ls_on = ls_want;
    end
    // Any turn-off restarts the dead time, including the forced one
    // when both are asked for, so the other switch cannot follow at once
    if (st_reg.hs_on && !st_next.hs_on)
      st_next.dead = DCNT_W'(DEAD_HL_CYC); // RL7
    if (st_reg.ls_on && !st_next.ls_on)
      st_next.dead = DCNT_W'(DEAD_LH_CYC); // RL7
    if (!rst_n) st_next = '0;
  end

  // State register
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  assign hs_oc_flag = st_reg.hs_flag;
  assign ls_oc_flag = st_reg.ls_flag;
  assign hs_on = st_reg.hs_on;
  assign ls_on = st_reg.ls_on;

  a_never_both: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(hs_on && ls_on)) else $error("both switches on"); // RL7
  a_flag_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    hs_oc_flag |-> !hs_on) else $error("hs on while flagged"); // RL4
  a_dead_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(hs_on) |-> !ls_on [*2]) else $error("no dead time"); // RL7
endmodule

// file: rtl/hbfs_pkg.sv
// Package: constants and carrier types for the half-bridge fault supervisor
package hbfs_pkg;
  localparam int NUM_HB = 12;
  localparam int CLK_MHZ = 125;
  // Register offsets
  localparam logic [3:0] ADDR_GLOBAL = 4'h0;
  localparam logic [3:0] ADDR_HS_OC  = 4'h1;
  localparam logic [3:0] ADDR_LS_OC  = 4'h2;
  localparam logic [3:0] ADDR_HS_ACT = 4'h3;
  localparam logic [3:0] ADDR_LS_ACT = 4'h4;
  // Global status register bit positions
  localparam int GS_TPW   = 1;
  localparam int GS_TSD   = 2;
  localparam int GS_POWUP = 3;
  localparam int GS_OV    = 4;
  localparam int GS_UV    = 5;
  localparam int GS_LE    = 6;
  localparam logic [7:0] GS_RESET = 8'h00;
  // Timing: filter and dead times in nanoseconds
  localparam int SD_FILTER_NS = 10000;
  localparam int DEAD_HL_NS   = 200;
  localparam int DEAD_LH_NS   = 200;
  localparam int SD_FILTER_CYC = (SD_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_HL_CYC = (DEAD_HL_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_LH_CYC = (DEAD_LH_NS * CLK_MHZ + 999) / 1000;
  localparam int FCNT_W = 11;
  localparam int DCNT_W = 6;
  localparam logic [NUM_HB-1:0] HB_ZERO = 12'h000;
  // Register port bundle
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } hbfs_bus_req_t;
  // Analog monitor levels, raw from comparators
  typedef struct packed {
    logic temp_warn;
    logic temp_sd;
    logic supply_undervoltage_flag;
    logic supply_overvoltage_flag;
  } hbfs_mon_t;
endpackage

// file: rtl/hbfs_top.sv
// Top: fault supervisor for twelve half-bridges with register port
// What this block does
// [RL1] Detect overcurrent on every high and low switch
// [RL2] Filtered overcurrent latches switch off and flag
// [RL3] Overcurrent also sets global load fault bit
// [RL4] Switch stays off while its flag set
// [RL5] Host clears overcurrent flag to re-arm switch
// [RL6] Activation bits stay 1 during overcurrent shutdown
// [RL7] Never both switches on; dead time between
// [RL8] Thermal warning sets flag, outputs stay active
// [RL9] Warning latched until cleared; re-sets if hot
// [RL10] Thermal shutdown latches all outputs off
// [RL11] Outputs off until shutdown bit cleared
// [RL12] Host clears shutdown bit to resume
// [RL13] Supply undervoltage: outputs off, flag latched
// [RL14] Undervoltage recovery reactivates stages automatically
// [RL15] Host clears undervoltage flag to recheck
// [RL16] Supply overvoltage: outputs off, flag latched
// [RL17] Overvoltage recovery reactivates stages automatically
// [RL18] Host clears overvoltage flag to recheck
// [RL19] Logic undervoltage resets and tristates all outputs
// [RL20] Reset held until logic supply valid
// [RL21] Power-up indication reads 0 after reset
// [RL22] Load fault at global bit 6
// [RL23] Thermal shutdown at global bit 2
// [RL24] Undervoltage at global bit 5
// [RL25] Overvoltage at global bit 4
// [RL26] Persisting fault re-sets flag after clear
module hbfs_top
  import hbfs_pkg::*;
(
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // Register port
  input  wire hbfs_pkg::hbfs_bus_req_t      bus_req,
  output logic [15:0]                       bus_rdata,
  // Analog monitors, asynchronous
  input  wire hbfs_pkg::hbfs_mon_t          mon_raw,
  input  wire logic [hbfs_pkg::NUM_HB-1:0]  hs_oc_raw,
  input  wire logic [hbfs_pkg::NUM_HB-1:0]  ls_oc_raw,
  input  wire logic                         logic_supply_ok,
  input  wire logic                         activation_pin,
  // Power stage drive
  output logic [hbfs_pkg::NUM_HB-1:0]       high_side_switch_on,
  output logic [hbfs_pkg::NUM_HB-1:0]       low_side_switch_on,
  output logic [hbfs_pkg::NUM_HB-1:0]       stage_oe
);
  import hbfs_pkg::*;

  typedef struct packed {
    hbfs_mon_t         mon_s1;
    hbfs_mon_t         mon_s2;
    logic [NUM_HB-1:0] hs_s1;
    logic [NUM_HB-1:0] hs_s2;
    logic [NUM_HB-1:0] ls_s1;
    logic [NUM_HB-1:0] ls_s2;
    logic [1:0]        sup_s; // logic supply, activation pin
    logic [1:0]        sup_s2;
    logic              thermal_warning_flag;
    logic              thermal_shutdown_flag;
    logic              uv;
    logic              ov;
    logic              powup;
    logic [NUM_HB-1:0] hs_act;
    logic [NUM_HB-1:0] ls_act;
    logic [15:0]       rdata;
  } hbfs_top_st_t;

  hbfs_top_st_t st_reg, st_next;
  logic [NUM_HB-1:0] hs_flag, ls_flag, hs_clr, ls_clr, hs_on, ls_on;
  logic              stage_ok;
  logic              core_rst_n;
  logic [7:0]        gstat;
  logic              wr_glob;

  // Digital reset: pin reset or logic supply below its level
  assign core_rst_n = rst_n && st_reg.sup_s2[1]; // RL19 RL20

  // Global status byte assembled from latched flags
  always_comb begin
    gstat = GS_RESET;
    gstat[GS_TPW] = st_reg.thermal_warning_flag;
    gstat[GS_TSD] = st_reg.thermal_shutdown_flag; // RL23
    gstat[GS_POWUP] = st_reg.powup;
    gstat[GS_OV] = st_reg.ov; // RL25
    gstat[GS_UV] = st_reg.uv; // RL24
    gstat[GS_LE] = |{hs_flag, ls_flag}; // RL3 RL22
  end

  // Supplies in range and no thermal latch; uses live levels so
  // recovery needs no host clear
  assign stage_ok = !st_reg.thermal_shutdown_flag && !st_reg.mon_s2.supply_undervoltage_flag
                    && !st_reg.mon_s2.supply_overvoltage_flag; // RL11 RL14 RL17

  assign wr_glob = bus_req.wr && bus_req.addr == ADDR_GLOBAL;
  assign hs_clr = (bus_req.wr && bus_req.addr == ADDR_HS_OC)
                  ? bus_req.wdata[NUM_HB-1:0] : HB_ZERO; // RL5
  assign ls_clr = (bus_req.wr && bus_req.addr == ADDR_LS_OC)
                  ? bus_req.wdata[NUM_HB-1:0] : HB_ZERO; // RL5

  // Next state: synchronisers, latches, register port
  always_comb begin
    st_next = st_reg;
    st_next.mon_s1 = mon_raw;
    st_next.mon_s2 = st_reg.mon_s1;
    st_next.hs_s1 = hs_oc_raw;
    st_next.hs_s2 = st_reg.hs_s1;
    st_next.ls_s1 = ls_oc_raw;
    st_next.ls_s2 = st_reg.ls_s1;
    st_next.sup_s = {logic_supply_ok, activation_pin};
    st_next.sup_s2 = st_reg.sup_s;
    // Write-one-to-clear of global flags; set wins over clear
    if (wr_glob) begin
      if (bus_req.wdata[GS_TPW]) st_next.thermal_warning_flag = 1'b0;
      if (bus_req.wdata[GS_TSD]) st_next.thermal_shutdown_flag = 1'b0; // RL12
      if (bus_req.wdata[GS_UV]) st_next.uv = 1'b0; // RL15
      if (bus_req.wdata[GS_OV]) st_next.ov = 1'b0; // RL18
    end
    if (st_reg.mon_s2.temp_warn) st_next.thermal_warning_flag = 1'b1; // RL8 RL9 RL26
    if (st_reg.mon_s2.temp_sd) st_next.thermal_shutdown_flag = 1'b1; // RL10 RL26
    if (st_reg.mon_s2.supply_undervoltage_flag) st_next.uv = 1'b1; // RL13 RL26
    if (st_reg.mon_s2.supply_overvoltage_flag) st_next.ov = 1'b1; // RL16 RL26
    // Power-up indication: 0 after reset until host writes it to 1,
    // accepted only in normal mode with the activation pin high
    if (wr_glob && bus_req.wdata[GS_POWUP] && st_reg.sup_s2[0])
      st_next.powup = 1'b1; // RL21
    // Activation bits are software-only; only host writes, reset or logic supply loss change them
    if (bus_req.wr && bus_req.addr == ADDR_HS_ACT)
      st_next.hs_act = bus_req.wdata[NUM_HB-1:0]; // RL6
    if (bus_req.wr && bus_req.addr == ADDR_LS_ACT)
      st_next.ls_act = bus_req.wdata[NUM_HB-1:0]; // RL6
    // Read data valid in the cycle after the strobe only
    st_next.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_GLOBAL: st_next.rdata = {8'h00, gstat};
        ADDR_HS_OC:  st_next.rdata = {4'h0, hs_flag};
        ADDR_LS_OC:  st_next.rdata = {4'h0, ls_flag};
        ADDR_HS_ACT: st_next.rdata = {4'h0, st_reg.hs_act};
        ADDR_LS_ACT: st_next.rdata = {4'h0, st_reg.ls_act};
        default:     st_next.rdata = '0;
      endcase
    end
    if (!core_rst_n) begin
      st_next = '0; // RL19 RL21
      st_next.sup_s = {logic_supply_ok, activation_pin};
      st_next.sup_s2 = st_reg.sup_s;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    st_reg <= st_next;
  end

  // One leg per half-bridge
  genvar g;
  generate
    for (g = 0; g < NUM_HB; g++) begin : g_leg
      hbfs_leg u_leg (
        .core_clk   (core_clk),
        .rst_n      (core_rst_n),
        .hs_act     (st_reg.hs_act[g]),
        .ls_act     (st_reg.ls_act[g]),
        .stage_ok   (stage_ok),
        .hs_oc_raw  (st_reg.hs_s2[g]),
        .ls_oc_raw  (st_reg.ls_s2[g]),
        .hs_clr     (hs_clr[g]),
        .ls_clr     (ls_clr[g]),
        .hs_oc_flag (hs_flag[g]),
        .ls_oc_flag (ls_flag[g]),
        .hs_on      (hs_on[g]),
        .ls_on      (ls_on[g])
      );
    end
  endgenerate

  assign high_side_switch_on = hs_on;
  assign low_side_switch_on = ls_on;
  // Stage is high impedance unless one of its switches drives
  assign stage_oe = hs_on | ls_on; // RL19
  assign bus_rdata = st_reg.rdata;

  a_tsd_all_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_reg.thermal_shutdown_flag |-> ##1 (stage_oe == HB_ZERO))
    else $error("output on during thermal shutdown"); // RL10
  a_le_follows: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    bus_req.rd && bus_req.addr == ADDR_GLOBAL && (|{hs_flag, ls_flag})
    |=> bus_rdata[GS_LE]) else $error("load fault missing"); // RL3
  a_uv_latch: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    st_reg.mon_s2.supply_undervoltage_flag |=> st_reg.uv) else $error("uv not latched"); // RL13
  a_ov_latch: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    st_reg.mon_s2.supply_overvoltage_flag |=> st_reg.ov) else $error("ov not latched"); // RL16
  a_warn_keeps: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    st_reg.mon_s2.temp_warn |=> st_reg.thermal_warning_flag) else $error("tpw lost"); // RL9
  a_act_kept: assert property (@(posedge core_clk) disable iff (!core_rst_n)
    !(bus_req.wr && bus_req.addr == ADDR_HS_ACT) |=> $stable(st_reg.hs_act))
    else $error("activation bit changed"); // RL6
  a_powup_low: assert property (@(posedge core_clk)
    !core_rst_n |=> !st_reg.powup) else $error("power-up bit set"); // RL21
endmodule
